/* File: srnv_pkg.sv */
/*
 * constants, codes and event carriers of the reset and nmi vector generator
 * assumes a 32-bit apb slave with a 12-bit byte address on the main clock
 */
package srnv_pkg;

    // ------------------------------------------------------------------
    // register indices; byte address is four times the index
    // ------------------------------------------------------------------
    localparam int         APB_AW          = 12;
    localparam int         IDX_W           = 10;
    localparam logic [9:0] IDX_USER_NMI    = 10'h15A;
    localparam logic [9:0] IDX_SYS_NMI     = 10'h15C;
    localparam logic [9:0] IDX_RST_CAUSE   = 10'h15E;
    localparam logic [9:0] IDX_MBX_IN      = 10'h160;
    localparam logic [9:0] IDX_MBX_OUT     = 10'h162;
    localparam logic [9:0] IDX_MBX_STAT    = 10'h164;

    // ------------------------------------------------------------------
    // field positions and reset values
    // ------------------------------------------------------------------
    localparam int          MBX_W          = 16;
    localparam int          VEC_W          = 16;
    localparam int          STAT_IN_FULL   = 0;
    localparam int          STAT_OUT_FULL  = 1;
    localparam logic [31:0] REG_RESET      = 32'h0000_0000;
    localparam logic [15:0] MBX_RESET      = 16'h0000;

    // ------------------------------------------------------------------
    // vector codes, lower code wins
    // ------------------------------------------------------------------
    localparam logic [7:0] VEC_NONE        = 8'h00;
    localparam logic [7:0] RC_BROWNOUT     = 8'h02;
    localparam logic [7:0] RC_RST_PIN      = 8'h04;
    localparam logic [7:0] RC_SW_BOR       = 8'h06;
    localparam logic [7:0] RC_LPM_WAKE     = 8'h08;
    localparam logic [7:0] RC_SECURITY     = 8'h0A;
    localparam logic [7:0] RC_SVSH         = 8'h0E;
    localparam logic [7:0] RC_SW_POR       = 8'h14;
    localparam logic [7:0] RC_WDT_EXPIRY   = 8'h16;
    localparam logic [7:0] RC_WDT_PASSWD   = 8'h18;
    localparam logic [7:0] RC_NVM_PASSWD   = 8'h1A;
    localparam logic [7:0] RC_NVM_UNCORR   = 8'h1C;
    localparam logic [7:0] RC_PERIPH_FETCH = 8'h1E;
    localparam logic [7:0] RC_PMM_PASSWD   = 8'h20;
    localparam logic [7:0] RC_FLL_UNLOCK   = 8'h24;
    localparam logic [7:0] SN_SVS_LP_ENTRY = 8'h02;
    localparam logic [7:0] SN_NVM_UNCORR   = 8'h04;
    localparam logic [7:0] SN_VACANT       = 8'h12;
    localparam logic [7:0] SN_MBX_IN       = 8'h14;
    localparam logic [7:0] SN_MBX_OUT      = 8'h16;
    localparam logic [7:0] SN_NVM_CORR     = 8'h18;
    localparam logic [7:0] UN_NMI_SVSH     = 8'h02;
    localparam logic [7:0] UN_OSC_FAULT    = 8'h04;

    // slot counts: slot k carries code 2*(k+1)
    localparam int RC_SLOTS = 18;
    localparam int SN_SLOTS = 12;
    localparam int UN_SLOTS = 2;

    // ------------------------------------------------------------------
    // event carriers, each bit a one-cycle pulse
    // ------------------------------------------------------------------
    typedef struct packed {
        logic brownout;
        logic reset_pin_flag;
        logic software_brownout_request;
        logic lpm_wake;
        logic security;
        logic high_supply_supervisor_flag;
        logic software_poweron_request;
        logic watchdog_expiry_flag;
        logic watchdog_password;
        logic nvm_controller_password;
        logic periph_fetch;
        logic power_mgmt_password;
        logic frequency_lock_loop_unlock;
    } srnv_rst_evt_s;

    typedef struct packed {
        logic svs_lp_entry;
        logic nvm_uncorrectable;
        logic vacant_access_flag;
        logic nvm_correctable;
    } srnv_snmi_evt_s;

    // slot index of a vector code
    function automatic int slot(input logic [7:0] code);
        return int'(code[7:1]) - 1;
    endfunction : slot

endpackage : srnv_pkg

/* File: srnv_flags.sv */
/*
 * bank of sticky event flags, one per slot
 * assumes set and clear pulses on the main clock
 */
`timescale 1ns/100ps
module srnv_flags #(
    parameter int N = 4
) (
    input  wire logic         i_clk,
    input  wire logic         i_rst_b,
    input  wire logic [N-1:0] i_set,
    input  wire logic [N-1:0] i_clr,
    output logic      [N-1:0] o_flag
);

    // ------------------------------------------------------------------
    // flags
    // ------------------------------------------------------------------
    genvar k;
    generate
        for (k = 0; k < N; k++) begin : g_flag
            // a set in the clearing cycle wins so no event is lost
            always_ff @(posedge i_clk or negedge i_rst_b) begin
                if (!i_rst_b) begin
                    o_flag[k] <= 1'b0;
                end else if (i_set[k]) begin
                    o_flag[k] <= 1'b1;
                end else if (i_clr[k]) begin
                    o_flag[k] <= 1'b0;
                end
            end
        end
    endgenerate

endmodule : srnv_flags

/* File: srnv_prio.sv */
/*
 * priority encoder: lowest pending slot gives code 2*(slot+1), none gives 0
 * assumes pending flags from a srnv_flags bank
 */
`timescale 1ns/100ps
module srnv_prio #(
    parameter int N = 4
) (
    input  wire logic [N-1:0] i_pending,
    output logic      [N-1:0] o_onehot,
    output logic      [7:0]   o_code
);

    // ------------------------------------------------------------------
    // winner selection
    // ------------------------------------------------------------------
    genvar k;
    generate
        for (k = 0; k < N; k++) begin : g_win
            if (k == 0) begin : g_first
                assign o_onehot[k] = i_pending[k];
            end else begin : g_rest
                assign o_onehot[k] = i_pending[k] & ~(|i_pending[k-1:0]);
            end
        end
    endgenerate

    // code of the one-hot winner, zero when idle
    always_comb begin
        o_code = srnv_pkg::VEC_NONE;
        for (int i = 0; i < N; i++) begin
            if (o_onehot[i]) begin
                o_code = o_code | 8'((i + 1) * 2);
            end
        end
    end

endmodule : srnv_prio

/* File: srnv_top.sv */
/*
 * reset-cause, system nmi and user nmi vector generator with debug mailbox
 * assumes event pulses from logic on the main clock, an asynchronous nmi pin,
 * an apb3 master on the main clock and a debug port on the main clock
 */
`timescale 1ns/100ps

// How it works
// - reset-cause vector: lowest pending code, else zero
// - brownout 02h, reset pin 04h, soft brownout 06h
// - low-power wake 08h, security 0Ah, supervisor 0Eh
// - software power-on request reports 14h
// - watchdog expiry 16h, watchdog password 18h
// - memory controller password violation reports 1Ah
// - uncorrectable memory error: 1Ch and nmi 04h
// - peripheral area fetch reports 1Eh
// - power password 20h, lock loss 24h
// - system nmi vector, supervisor entry 02h
// - vacant memory access reports 12h
// - mailbox input arrival reports 14h
// - mailbox output ready reports 16h
// - correctable memory error reports 18h
// - user nmi: pin/supervisor 02h, oscillator 04h
// - two-way mailbox between debug and software
module srnv_top (
    input  wire logic                              I_MCLK,
    input  wire logic                              I_RST_B,
    input  wire logic                              I_PSEL,
    input  wire logic                              I_PENABLE,
    input  wire logic                              I_PWRITE,
    input  wire logic [srnv_pkg::APB_AW-1:0]       I_PADDR,
    input  wire logic [31:0]                       I_PWDATA,
    output logic      [31:0]                       O_PRDATA,
    output logic                                   O_PREADY,
    output logic                                   O_PSLVERR,
    input  wire srnv_pkg::srnv_rst_evt_s           I_RST_EVT,
    input  wire srnv_pkg::srnv_snmi_evt_s          I_SNMI_EVT,
    input  wire logic                              I_NMI_PIN,
    input  wire logic                              I_SVSH_EVT,
    input  wire logic                              I_OSC_FAULT,
    input  wire logic                              I_DBG_IN_WR,
    input  wire logic [srnv_pkg::MBX_W-1:0]        I_DBG_IN_DATA,
    input  wire logic                              I_DBG_OUT_RD,
    output logic      [srnv_pkg::MBX_W-1:0]        O_DBG_OUT_DATA,
    output logic                                   O_DBG_OUT_FULL,
    output logic                                   O_DBG_IN_FULL
);

    // ------------------------------------------------------------------
    // declarations
    // ------------------------------------------------------------------
    logic [srnv_pkg::RC_SLOTS-1:0] rc_set;
    logic [srnv_pkg::RC_SLOTS-1:0] rc_clr;
    logic [srnv_pkg::RC_SLOTS-1:0] rc_pend;
    logic [srnv_pkg::RC_SLOTS-1:0] rc_hot;
    logic [7:0]                    rc_code;
    logic [srnv_pkg::SN_SLOTS-1:0] sn_set;
    logic [srnv_pkg::SN_SLOTS-1:0] sn_clr;
    logic [srnv_pkg::SN_SLOTS-1:0] sn_pend;
    logic [srnv_pkg::SN_SLOTS-1:0] sn_hot;
    logic [7:0]                    sn_code;
    logic [srnv_pkg::UN_SLOTS-1:0] un_set;
    logic [srnv_pkg::UN_SLOTS-1:0] un_clr;
    logic [srnv_pkg::UN_SLOTS-1:0] un_pend;
    logic [srnv_pkg::UN_SLOTS-1:0] un_hot;
    logic [7:0]                    un_code;
    logic                          nmi_meta_r;
    logic                          nmi_sync_r;
    logic                          nmi_prev_r;
    logic                          nmi_rise;
    logic                          ready_r;
    logic                          acc_first;
    logic                          acc_done;
    logic [srnv_pkg::IDX_W-1:0]    idx;
    logic                          aligned;
    logic                          hit_un;
    logic                          hit_sn;
    logic                          hit_rc;
    logic                          hit_mi;
    logic                          hit_mo;
    logic                          hit_st;
    logic                          hit;
    logic                          rd_first;
    logic [31:0]                   rdata_nxt;
    logic [31:0]                   rdata_r;
    logic                          slverr_r;
    logic [srnv_pkg::MBX_W-1:0]    mbx_in_r;
    logic                          in_full_r;
    logic [srnv_pkg::MBX_W-1:0]    mbx_out_r;
    logic                          out_full_r;
    logic                          mbx_in_evt;
    logic                          mbx_out_evt;
    logic                          app_out_wr;
    logic                          app_in_rd;

    // ------------------------------------------------------------------
    // nmi pin synchroniser and rising edge
    // ------------------------------------------------------------------
    always_ff @(posedge I_MCLK or negedge I_RST_B) begin
        if (!I_RST_B) begin
            nmi_meta_r <= 1'b0;
            nmi_sync_r <= 1'b0;
            nmi_prev_r <= 1'b0;
        end else begin
            nmi_meta_r <= I_NMI_PIN;
            nmi_sync_r <= nmi_meta_r;
            nmi_prev_r <= nmi_sync_r;
        end
    end

    assign nmi_rise = nmi_sync_r & ~nmi_prev_r;

    // ------------------------------------------------------------------
    // event to slot mapping
    // ------------------------------------------------------------------
    always_comb begin
        rc_set = '0;
        rc_set[srnv_pkg::slot(srnv_pkg::RC_BROWNOUT)]     = I_RST_EVT.brownout;
        rc_set[srnv_pkg::slot(srnv_pkg::RC_RST_PIN)]      = I_RST_EVT.reset_pin_flag;
        rc_set[srnv_pkg::slot(srnv_pkg::RC_SW_BOR)]       = I_RST_EVT.software_brownout_request;
        rc_set[srnv_pkg::slot(srnv_pkg::RC_LPM_WAKE)]     = I_RST_EVT.lpm_wake;
        rc_set[srnv_pkg::slot(srnv_pkg::RC_SECURITY)]     = I_RST_EVT.security;
        rc_set[srnv_pkg::slot(srnv_pkg::RC_SVSH)]         = I_RST_EVT.high_supply_supervisor_flag;
        rc_set[srnv_pkg::slot(srnv_pkg::RC_SW_POR)]       = I_RST_EVT.software_poweron_request;
        rc_set[srnv_pkg::slot(srnv_pkg::RC_WDT_EXPIRY)]   = I_RST_EVT.watchdog_expiry_flag;
        rc_set[srnv_pkg::slot(srnv_pkg::RC_WDT_PASSWD)]   = I_RST_EVT.watchdog_password;
        rc_set[srnv_pkg::slot(srnv_pkg::RC_NVM_PASSWD)]   = I_RST_EVT.nvm_controller_password;
        rc_set[srnv_pkg::slot(srnv_pkg::RC_NVM_UNCORR)]   = I_SNMI_EVT.nvm_uncorrectable;
        rc_set[srnv_pkg::slot(srnv_pkg::RC_PERIPH_FETCH)] = I_RST_EVT.periph_fetch;
        rc_set[srnv_pkg::slot(srnv_pkg::RC_PMM_PASSWD)]   = I_RST_EVT.power_mgmt_password;
        rc_set[srnv_pkg::slot(srnv_pkg::RC_FLL_UNLOCK)]   = I_RST_EVT.frequency_lock_loop_unlock;
    end

    // reserved slots stay tied low so they never win
    always_comb begin
        sn_set = '0;
        sn_set[srnv_pkg::slot(srnv_pkg::SN_SVS_LP_ENTRY)] = I_SNMI_EVT.svs_lp_entry;
        sn_set[srnv_pkg::slot(srnv_pkg::SN_NVM_UNCORR)]   = I_SNMI_EVT.nvm_uncorrectable;
        sn_set[srnv_pkg::slot(srnv_pkg::SN_VACANT)]       = I_SNMI_EVT.vacant_access_flag;
        sn_set[srnv_pkg::slot(srnv_pkg::SN_MBX_IN)]       = mbx_in_evt;
        sn_set[srnv_pkg::slot(srnv_pkg::SN_MBX_OUT)]      = mbx_out_evt;
        sn_set[srnv_pkg::slot(srnv_pkg::SN_NVM_CORR)]     = I_SNMI_EVT.nvm_correctable;
    end

    always_comb begin
        un_set = '0;
        un_set[srnv_pkg::slot(srnv_pkg::UN_NMI_SVSH)]  = nmi_rise | I_SVSH_EVT;
        un_set[srnv_pkg::slot(srnv_pkg::UN_OSC_FAULT)] = I_OSC_FAULT;
    end

    // ------------------------------------------------------------------
    // pending flags and priority encoders
    // ------------------------------------------------------------------
    srnv_flags #(.N(srnv_pkg::RC_SLOTS)) u_rc_flags (
        .i_clk   (I_MCLK),
        .i_rst_b (I_RST_B),
        .i_set   (rc_set),
        .i_clr   (rc_clr),
        .o_flag  (rc_pend)
    );

    srnv_prio #(.N(srnv_pkg::RC_SLOTS)) u_rc_prio (
        .i_pending (rc_pend),
        .o_onehot  (rc_hot),
        .o_code    (rc_code)
    );

    srnv_flags #(.N(srnv_pkg::SN_SLOTS)) u_sn_flags (
        .i_clk   (I_MCLK),
        .i_rst_b (I_RST_B),
        .i_set   (sn_set),
        .i_clr   (sn_clr),
        .o_flag  (sn_pend)
    );

    srnv_prio #(.N(srnv_pkg::SN_SLOTS)) u_sn_prio (
        .i_pending (sn_pend),
        .o_onehot  (sn_hot),
        .o_code    (sn_code)
    );

    srnv_flags #(.N(srnv_pkg::UN_SLOTS)) u_un_flags (
        .i_clk   (I_MCLK),
        .i_rst_b (I_RST_B),
        .i_set   (un_set),
        .i_clr   (un_clr),
        .o_flag  (un_pend)
    );

    srnv_prio #(.N(srnv_pkg::UN_SLOTS)) u_un_prio (
        .i_pending (un_pend),
        .o_onehot  (un_hot),
        .o_code    (un_code)
    );

    // ------------------------------------------------------------------
    // apb phase tracking and address decode
    // ------------------------------------------------------------------
    assign acc_first = I_PSEL & I_PENABLE & ~ready_r;
    assign acc_done  = I_PSEL & I_PENABLE & ready_r;
    assign idx       = I_PADDR[srnv_pkg::APB_AW-1:2];
    assign aligned   = (I_PADDR[1:0] == 2'b00);
    assign hit_un    = aligned & (idx == srnv_pkg::IDX_USER_NMI);
    assign hit_sn    = aligned & (idx == srnv_pkg::IDX_SYS_NMI);
    assign hit_rc    = aligned & (idx == srnv_pkg::IDX_RST_CAUSE);
    assign hit_mi    = aligned & (idx == srnv_pkg::IDX_MBX_IN);
    assign hit_mo    = aligned & (idx == srnv_pkg::IDX_MBX_OUT);
    assign hit_st    = aligned & (idx == srnv_pkg::IDX_MBX_STAT);
    assign hit       = hit_un | hit_sn | hit_rc | hit_mi | hit_mo | hit_st;
    assign rd_first  = acc_first & ~I_PWRITE;

    // one wait state: ready rises in the second access cycle
    always_ff @(posedge I_MCLK or negedge I_RST_B) begin
        if (!I_RST_B) begin
            ready_r <= 1'b0;
        end else begin
            ready_r <= acc_first;
        end
    end

    // ------------------------------------------------------------------
    // read data and clear on read
    // ------------------------------------------------------------------
    always_comb begin
        rdata_nxt = srnv_pkg::REG_RESET;
        if (hit_rc) begin
            rdata_nxt[srnv_pkg::VEC_W-1:0] = {8'h00, rc_code};
        end else if (hit_sn) begin
            rdata_nxt[srnv_pkg::VEC_W-1:0] = {8'h00, sn_code};
        end else if (hit_un) begin
            rdata_nxt[srnv_pkg::VEC_W-1:0] = {8'h00, un_code};
        end else if (hit_mi) begin
            rdata_nxt[srnv_pkg::MBX_W-1:0] = mbx_in_r;
        end else if (hit_mo) begin
            rdata_nxt[srnv_pkg::MBX_W-1:0] = mbx_out_r;
        end else if (hit_st) begin
            rdata_nxt[srnv_pkg::STAT_IN_FULL]  = in_full_r;
            rdata_nxt[srnv_pkg::STAT_OUT_FULL] = out_full_r;
        end
    end

    // the flag that was reported is the one retired, in the same edge
    assign rc_clr = (rd_first & hit_rc) ? rc_hot : '0;
    assign sn_clr = (rd_first & hit_sn) ? sn_hot : '0;
    assign un_clr = (rd_first & hit_un) ? un_hot : '0;

    // answer registers: data held until the next access, error only beside ready
    always_ff @(posedge I_MCLK or negedge I_RST_B) begin
        if (!I_RST_B) begin
            rdata_r  <= srnv_pkg::REG_RESET;
            slverr_r <= 1'b0;
        end else begin
            slverr_r <= acc_first & ~hit;
            if (acc_first) begin
                rdata_r <= I_PWRITE ? srnv_pkg::REG_RESET : rdata_nxt;
            end
        end
    end

    assign O_PRDATA  = rdata_r;
    assign O_PREADY  = ready_r;
    assign O_PSLVERR = slverr_r;

    // ------------------------------------------------------------------
    // debug mailbox
    // ------------------------------------------------------------------
    // writes to the vector registers fall through with no effect
    assign app_out_wr  = acc_done & I_PWRITE & hit_mo & ~slverr_r;
    assign app_in_rd   = rd_first & hit_mi;
    assign mbx_in_evt  = I_DBG_IN_WR;
    assign mbx_out_evt = I_DBG_OUT_RD & out_full_r;

    // inbound word from the debug side
    always_ff @(posedge I_MCLK or negedge I_RST_B) begin
        if (!I_RST_B) begin
            mbx_in_r  <= srnv_pkg::MBX_RESET;
            in_full_r <= 1'b0;
        end else if (I_DBG_IN_WR) begin
            mbx_in_r  <= I_DBG_IN_DATA;
            in_full_r <= 1'b1;
        end else if (app_in_rd) begin
            in_full_r <= 1'b0;
        end
    end

    // outbound word from software; a write in the drain cycle wins
    always_ff @(posedge I_MCLK or negedge I_RST_B) begin
        if (!I_RST_B) begin
            mbx_out_r  <= srnv_pkg::MBX_RESET;
            out_full_r <= 1'b0;
        end else if (app_out_wr) begin
            mbx_out_r  <= I_PWDATA[srnv_pkg::MBX_W-1:0];
            out_full_r <= 1'b1;
        end else if (mbx_out_evt) begin
            out_full_r <= 1'b0;
        end
    end

    assign O_DBG_OUT_DATA = mbx_out_r;
    assign O_DBG_OUT_FULL = out_full_r;
    assign O_DBG_IN_FULL  = in_full_r;

endmodule : srnv_top

/* File: srnv_properties.sv */
/*
 * concurrent checks on the apb side and mailbox ports of srnv_top
 * assumes a single main clock domain and the active-low asynchronous reset
 */
`timescale 1ns/100ps
module srnv_chk (
    input wire logic        I_MCLK,
    input wire logic        I_RST_B,
    input wire logic        I_PSEL,
    input wire logic        I_PENABLE,
    input wire logic        I_PWRITE,
    input wire logic [11:0] I_PADDR,
    input wire logic [31:0] I_PWDATA,
    input wire logic [31:0] O_PRDATA,
    input wire logic        O_PREADY,
    input wire logic        O_PSLVERR,
    input wire logic        I_DBG_IN_WR,
    input wire logic        I_DBG_OUT_RD,
    input wire logic [15:0] O_DBG_OUT_DATA,
    input wire logic        O_DBG_OUT_FULL,
    input wire logic        O_DBG_IN_FULL
);
    // ------------------------------------------------------------------
    // one domain: shared clock and reset
    // ------------------------------------------------------------------
    default clocking cb @(posedge I_MCLK); endclocking
    default disable iff (!I_RST_B);
    logic acc;
    logic vec;
    // first access cycle and vector address decode
    assign acc = I_PSEL && I_PENABLE && !O_PREADY;
    assign vec = I_PADDR inside {12'h568, 12'h570, 12'h578};

    AST_RDY_ONE_WAIT: assert property (acc |=> O_PREADY) else $error("ready late");
    AST_RDY_PULSE: assert property (O_PREADY |=> !O_PREADY) else $error("ready too long");
    AST_BAD_ADDR: assert property (acc && (I_PADDR[1:0] != 2'b00 || I_PADDR == 12'h004) |=> O_PSLVERR)
        else $error("bad address accepted");
    AST_ERR_WITH_RDY: assert property (O_PSLVERR |-> O_PREADY && O_PRDATA == 32'h0000_0000)
        else $error("error without ready");
    AST_VEC_EVEN: assert property (O_PREADY && !I_PWRITE && vec |-> O_PRDATA[31:6] == 26'h0 && !O_PRDATA[0]
        && !O_PSLVERR) else $error("vector code malformed");
    AST_VEC_WR: assert property (O_PREADY && I_PWRITE && vec |-> !O_PSLVERR && O_PRDATA == 32'h0000_0000)
        else $error("vector write refused");
    AST_IN_FULL: assert property (I_DBG_IN_WR |=> O_DBG_IN_FULL) else $error("mailbox in not full");
    AST_OUT_WR: assert property (I_PSEL && I_PENABLE && O_PREADY && I_PWRITE && I_PADDR == 12'h588
        |=> O_DBG_OUT_FULL && {16'h0000, O_DBG_OUT_DATA} == ($past(I_PWDATA) & 32'h0000_FFFF))
        else $error("mailbox out not loaded");
    AST_OUT_TAKE: assert property (I_DBG_OUT_RD && O_DBG_OUT_FULL && !(I_PSEL && I_PENABLE && I_PWRITE)
        |=> !O_DBG_OUT_FULL) else $error("mailbox out not taken");
endmodule : srnv_chk

/* File: testbench.sv */
/*
 * self-checking bench of srnv_top: apb reads of the vector registers after events
 * assumes the design files compiled first and a 10 MHz main clock
 */
`timescale 1ns/100ps
module testbench;
    logic                    clk = 1'b0, rst_b = 1'b0, psel = 1'b0, pen = 1'b0, pwr = 1'b0;
    logic [11:0]             pa = 12'h000;
    logic [31:0]             pd = 32'h0, prdata;
    logic                    pready, pslverr, nmi = 1'b0, svsh = 1'b0, osc = 1'b0;
    logic                    in_wr = 1'b0, out_rd = 1'b0, out_full, in_full;
    logic [15:0]             in_data = 16'h0000, out_data;
    srnv_pkg::srnv_rst_evt_s  rst_evt = '0;
    srnv_pkg::srnv_snmi_evt_s snmi_evt = '0;
    int                      mismatches = 0, tests_run = 0, cyc = 0;
    logic [7:0] rc_exp [14] = '{8'h02, 8'h04, 8'h06, 8'h08, 8'h0A, 8'h0E, 8'h14, 8'h16, 8'h18, 8'h1A, 8'h1C,
                                8'h1E, 8'h20, 8'h24};
    logic [7:0] sn_exp [6] = '{8'h02, 8'h04, 8'h12, 8'h14, 8'h16, 8'h18};

    srnv_top dut (.I_MCLK(clk), .I_RST_B(rst_b), .I_PSEL(psel), .I_PENABLE(pen), .I_PWRITE(pwr),
        .I_PADDR(pa), .I_PWDATA(pd), .O_PRDATA(prdata), .O_PREADY(pready), .O_PSLVERR(pslverr),
        .I_RST_EVT(rst_evt), .I_SNMI_EVT(snmi_evt), .I_NMI_PIN(nmi), .I_SVSH_EVT(svsh), .I_OSC_FAULT(osc),
        .I_DBG_IN_WR(in_wr), .I_DBG_IN_DATA(in_data), .I_DBG_OUT_RD(out_rd), .O_DBG_OUT_DATA(out_data),
        .O_DBG_OUT_FULL(out_full), .O_DBG_IN_FULL(in_full));

    // ------------------------------------------------------------------
    // clock and hang guard
    // ------------------------------------------------------------------
    always #50 clk = ~clk;
    always @(posedge clk) begin
        cyc++;
        if (cyc == 4000) begin
            mismatches++;
            give_verdict();
        end
    end

    // ------------------------------------------------------------------
    // compare, bus cycle and verdict tasks
    // ------------------------------------------------------------------
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        tests_run++;
        if (seen !== exp) begin
            mismatches++;
            $display("FAIL %0t seen %h expected %h", $time, seen, exp);
        end
    endtask : check

    // setup, access, then hold until ready is sampled high
    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d, input logic [31:0] exp,
                       input logic err);
        @(posedge clk);
        psel <= 1'b1; pen <= 1'b0; pwr <= w; pa <= a; pd <= d;
        @(posedge clk);
        pen <= 1'b1;
        do @(posedge clk); while (pready !== 1'b1);
        check(prdata, exp);
        check({31'h0, pslverr}, {31'h0, err});
        psel <= 1'b0;
        pen <= 1'b0;
    endtask : apb

    task automatic rd(input logic [11:0] a, input logic [7:0] code);
        apb(1'b0, a, 32'h0, {24'h0, code}, 1'b0);
    endtask : rd

    task automatic give_verdict();
        if (mismatches == 0 && tests_run > 0) $display("No errors found");
        else $display("Errors were found");
        $finish;
    endtask : give_verdict

    // ------------------------------------------------------------------
    // main sequence
    // ------------------------------------------------------------------
    initial begin
        repeat (10) @(posedge clk);
        rst_b <= 1'b1;
        rd(12'h578, 8'h00);
        rd(12'h570, 8'h00);
        rd(12'h568, 8'h00);
        // every reset source and every system nmi source except mailbox output at once
        @(posedge clk);
        rst_evt <= '1; snmi_evt <= '1; in_wr <= 1'b1; in_data <= 16'hA5C3;
        @(posedge clk);
        rst_evt <= '0; snmi_evt <= '0; in_wr <= 1'b0;
        apb(1'b1, 12'h578, 32'h0000_FFFF, 32'h0, 1'b0);
        for (int i = 0; i < 14; i++) rd(12'h578, rc_exp[i]);
        rd(12'h578, 8'h00);
        check({31'h0, in_full}, 32'h1);
        apb(1'b0, 12'h580, 32'h0, 32'h0000_A5C3, 1'b0);
        check({31'h0, in_full}, 32'h0);
        apb(1'b1, 12'h588, 32'h0000_1234, 32'h0, 1'b0);
        @(posedge clk);
        check({15'h0, out_full, out_data}, 32'h0001_1234);
        apb(1'b0, 12'h590, 32'h0, 32'h0000_0002, 1'b0);
        out_rd <= 1'b1;
        @(posedge clk);
        out_rd <= 1'b0;
        for (int i = 0; i < 6; i++) rd(12'h570, sn_exp[i]);
        rd(12'h570, 8'h00);
        check({31'h0, out_full}, 32'h0);
        // user nmi sources, then the pin
        svsh <= 1'b1; osc <= 1'b1;
        @(posedge clk);
        svsh <= 1'b0; osc <= 1'b0;
        rd(12'h568, 8'h02);
        rd(12'h568, 8'h04);
        rd(12'h568, 8'h00);
        nmi <= 1'b1;
        repeat (4) @(posedge clk);
        rd(12'h568, 8'h02);
        apb(1'b0, 12'h004, 32'h0, 32'h0, 1'b1);
        apb(1'b1, 12'h57A, 32'h0, 32'h0, 1'b1);
        give_verdict();
    end
endmodule : testbench

bind srnv_top srnv_chk u_chk (.I_MCLK(I_MCLK), .I_RST_B(I_RST_B), .I_PSEL(I_PSEL), .I_PENABLE(I_PENABLE),
    .I_PWRITE(I_PWRITE), .I_PADDR(I_PADDR), .I_PWDATA(I_PWDATA), .O_PRDATA(O_PRDATA), .O_PREADY(O_PREADY),
    .O_PSLVERR(O_PSLVERR), .I_DBG_IN_WR(I_DBG_IN_WR), .I_DBG_OUT_RD(I_DBG_OUT_RD),
    .O_DBG_OUT_DATA(O_DBG_OUT_DATA), .O_DBG_OUT_FULL(O_DBG_OUT_FULL), .O_DBG_IN_FULL(O_DBG_IN_FULL));
